// ---- core/dsq_sequencer.sv ----
// Disk sector data phase sequencer with Wishbone register slave
`timescale 1ns/1ps
module dsq_sequencer (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq,
    input wire logic header_match,
    input wire logic header_post_done,
    output logic write_gate,
    output logic read_gate,
    output logic mfm_select,
    output logic address_mark_enable_output,
    output logic [7:0] wr_byte,
    output logic wr_byte_valid,
    input wire logic byte_tick,
    input wire logic [7:0] rd_byte,
    input wire logic rd_byte_valid,
    input wire logic [7:0] fifo_rd_data,
    input wire logic fifo_rd_valid,
    output logic fifo_rd_ready,
    output logic [7:0] fifo_wr_data,
    output logic fifo_wr_valid,
    input wire logic fifo_wr_ready
);
    ////////////////////////////////////////////////////////////////////////
    dsq_pkg::dsq_state_type state;
    logic [7:0] ctrl;
    logic [2:0] cmd;
    logic cmd_pending;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] sect_count;
    logic [7:0] start_sector;
    logic [7:0] pattern;
    logic [7:0] amark;
    logic [7:0] sync_pat;
    logic [15:0] field_cnt;
    logic [15:0] crc;
    logic crc_on;
    logic crc_bad;
    logic wb_hit;
    logic [2:0] ev_set;
    logic is_write;
    logic is_fmt;
    logic [1:0] op;

    assign op = cmd[1:0];
    assign is_fmt = (op == dsq_pkg::OP_FORMAT);
    assign is_write = (op == dsq_pkg::OP_WRITE) || is_fmt;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ dsq_pkg::CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one registered ack the cycle after the request, unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                dsq_pkg::ADDR_CTRL: wb_dat_o <= {24'h0, ctrl};
                dsq_pkg::ADDR_CMD: wb_dat_o <= {28'h0, cmd_pending, cmd};
                dsq_pkg::ADDR_STATUS: wb_dat_o <= {29'h0, status};
                dsq_pkg::ADDR_MASK: wb_dat_o <= {29'h0, mask};
                dsq_pkg::ADDR_COUNT: wb_dat_o <= {24'h0, sect_count};
                dsq_pkg::ADDR_PATTERN: wb_dat_o <= {24'h0, pattern};
                dsq_pkg::ADDR_AMARK: wb_dat_o <= {24'h0, amark};
                dsq_pkg::ADDR_SYNC: wb_dat_o <= {24'h0, sync_pat};
                dsq_pkg::ADDR_SECTOR: wb_dat_o <= {24'h0, start_sector};
                dsq_pkg::ADDR_STATE: wb_dat_o <= {28'h0, 4'(state)};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    logic wr_lo;
    assign wr_lo = wb_hit && wb_we_i && wb_sel_i[0];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl <= dsq_pkg::CTRL_RESET;
            mask <= 3'h0;
            pattern <= 8'h00;
            amark <= dsq_pkg::AMARK_RESET;
            sync_pat <= dsq_pkg::SYNC_RESET;
        end else if (wr_lo) begin
            case (wb_adr_i)
                dsq_pkg::ADDR_CTRL: ctrl <= wb_dat_i[7:0];
                dsq_pkg::ADDR_MASK: mask <= wb_dat_i[2:0];
                dsq_pkg::ADDR_PATTERN: pattern <= wb_dat_i[7:0];
                dsq_pkg::ADDR_AMARK: amark <= wb_dat_i[7:0];
                dsq_pkg::ADDR_SYNC: sync_pat <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Sticky status, cleared by reading; a same-cycle event wins
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            status <= 3'h0;
        end else if (wb_hit && !wb_we_i
                     && wb_adr_i == dsq_pkg::ADDR_STATUS) begin
            status <= ev_set;
        end else begin
            status <= status | ev_set;
        end
    end

    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    logic last_field;
    logic fifo_take;
    logic [7:0] next_wr_byte;
    assign last_field = (field_cnt == 16'h0001);
    assign fifo_take = (state == dsq_pkg::DSQ_WR_DATA) && byte_tick && !is_fmt;
    assign fifo_rd_ready = fifo_take;

    always_comb begin
        case (state)
            dsq_pkg::DSQ_WR_AM: next_wr_byte = amark;
            dsq_pkg::DSQ_WR_PRE: next_wr_byte = dsq_pkg::PRE_BYTE;
            dsq_pkg::DSQ_WR_SYNC: next_wr_byte = sync_pat;
            dsq_pkg::DSQ_WR_DATA:
                next_wr_byte = is_fmt ? pattern : fifo_rd_data;
            // The CRC shifts left after each byte, so the next one is on top
            dsq_pkg::DSQ_WR_CRC: next_wr_byte = crc[15:8];
            dsq_pkg::DSQ_WR_POST: next_wr_byte = dsq_pkg::POST_BYTE;
            dsq_pkg::DSQ_WR_GAP: next_wr_byte = dsq_pkg::GAP_BYTE;
            default: next_wr_byte = 8'h00;
        endcase
    end

    // Write underrun (no FIFO byte at a tick) aborts as well
    logic underrun;
    assign underrun = fifo_take && !fifo_rd_valid;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wr_byte <= 8'h00;
            wr_byte_valid <= 1'b0;
        end else begin
            wr_byte <= next_wr_byte;
            wr_byte_valid <= byte_tick && write_gate
                && state != dsq_pkg::DSQ_DONE && state != dsq_pkg::DSQ_IDLE
                && state != dsq_pkg::DSQ_WAIT_HDR;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fifo_wr_data <= 8'h00;
            fifo_wr_valid <= 1'b0;
        end else begin
            fifo_wr_valid <= (state == dsq_pkg::DSQ_RD_DATA) && rd_byte_valid
                && op == dsq_pkg::OP_READ;
            fifo_wr_data <= rd_byte;
        end
    end

    // CRC over written or received bytes
    logic crc_byte;
    logic [7:0] crc_in;
    assign crc_byte = crc_on && ((write_gate && byte_tick
        && (state == dsq_pkg::DSQ_WR_AM || state == dsq_pkg::DSQ_WR_PRE
        || state == dsq_pkg::DSQ_WR_SYNC || state == dsq_pkg::DSQ_WR_DATA))
        || (read_gate && rd_byte_valid && state != dsq_pkg::DSQ_RD_CRC));
    assign crc_in = write_gate ? next_wr_byte : rd_byte;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            crc <= dsq_pkg::CRC_SEED;
        end else if (state == dsq_pkg::DSQ_WAIT_HDR) begin
            crc <= dsq_pkg::CRC_SEED;
        end else if (crc_byte) begin
            crc <= crc_step(crc, crc_in);
        end else if (state == dsq_pkg::DSQ_WR_CRC && byte_tick) begin
            crc <= {crc[7:0], 8'h00};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= dsq_pkg::DSQ_IDLE;
            write_gate <= 1'b0;
            read_gate <= 1'b0;
            mfm_select <= 1'b0;
            address_mark_enable_output <= 1'b0;
            field_cnt <= 16'h0000;
            crc_on <= 1'b0;
            crc_bad <= 1'b0;
            cmd <= 3'h0;
            cmd_pending <= 1'b0;
            sect_count <= 8'h00;
            start_sector <= 8'h00;
            ev_set <= 3'h0;
        end else begin
            ev_set <= 3'h0;
            if (wr_lo && wb_adr_i == dsq_pkg::ADDR_COUNT) begin
                sect_count <= wb_dat_i[7:0];
            end
            if (wr_lo && wb_adr_i == dsq_pkg::ADDR_SECTOR) begin
                start_sector <= wb_dat_i[7:0];
            end
            if (wr_lo && wb_adr_i == dsq_pkg::ADDR_CMD) begin
                cmd <= wb_dat_i[2:0];
                cmd_pending <= 1'b1;
            end
            case (state)
                dsq_pkg::DSQ_IDLE: begin
                    if (cmd_pending) begin
                        cmd_pending <= 1'b0;
                        state <= dsq_pkg::DSQ_WAIT_HDR;
                    end
                end
                dsq_pkg::DSQ_WAIT_HDR: begin
                    crc_on <= 1'b0;
                    crc_bad <= 1'b0;
                    if (header_match) begin
                        read_gate <= 1'b0;
                        mfm_select <= ctrl[dsq_pkg::CTRL_MFM];
                        if (is_write) begin
                            write_gate <= 1'b1;
                            // Start-with-mark selects mark first
                            state <= ctrl[dsq_pkg::CTRL_START_AM]
                                ? dsq_pkg::DSQ_WR_AM : dsq_pkg::DSQ_WR_PRE;
                            field_cnt <= ctrl[dsq_pkg::CTRL_START_AM]
                                ? 16'(dsq_pkg::AM_LEN) : 16'(dsq_pkg::PRE_LEN);
                            crc_on <= ctrl[dsq_pkg::CTRL_ENCAP]
                                && ctrl[dsq_pkg::CTRL_START_AM];
                        end else begin
                            state <= dsq_pkg::DSQ_RD_AM;
                        end
                    end
                end
                dsq_pkg::DSQ_WR_AM: begin
                    address_mark_enable_output <= 1'b1;
                    if (byte_tick && last_field) begin
                        address_mark_enable_output <= 1'b0;
                        state <= ctrl[dsq_pkg::CTRL_START_AM]
                            ? dsq_pkg::DSQ_WR_PRE : dsq_pkg::DSQ_WR_SYNC;
                        field_cnt <= ctrl[dsq_pkg::CTRL_START_AM]
                            ? 16'(dsq_pkg::PRE_LEN) : 16'(dsq_pkg::SYNC_LEN);
                    end else if (byte_tick) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_WR_PRE: begin
                    if (byte_tick && last_field) begin
                        // A trailing mark must fall inside the CRC too
                        crc_on <= ctrl[dsq_pkg::CTRL_ENCAP];
                        state <= ctrl[dsq_pkg::CTRL_START_AM]
                            ? dsq_pkg::DSQ_WR_SYNC : dsq_pkg::DSQ_WR_AM;
                        field_cnt <= ctrl[dsq_pkg::CTRL_START_AM]
                            ? 16'(dsq_pkg::SYNC_LEN) : 16'(dsq_pkg::AM_LEN);
                    end else if (byte_tick) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_WR_SYNC: begin
                    if (byte_tick && last_field) begin
                        crc_on <= 1'b1;
                        state <= dsq_pkg::DSQ_WR_DATA;
                        field_cnt <= dsq_pkg::DATA_LEN_RESET;
                    end else if (byte_tick) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_WR_DATA: begin
                    if (underrun) begin
                        state <= dsq_pkg::DSQ_IDLE;
                        write_gate <= 1'b0;
                        ev_set[dsq_pkg::ST_ABORT] <= 1'b1;
                    end else if (byte_tick && last_field) begin
                        crc_on <= 1'b0;
                        state <= dsq_pkg::DSQ_WR_CRC;
                        field_cnt <= 16'(dsq_pkg::CRC_LEN);
                    end else if (byte_tick) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_WR_CRC: begin
                    if (byte_tick && last_field) begin
                        state <= dsq_pkg::DSQ_WR_POST;
                        field_cnt <= 16'(dsq_pkg::POST_LEN);
                    end else if (byte_tick) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_WR_POST: begin
                    if (byte_tick && last_field) begin
                        if (is_fmt) begin
                            state <= dsq_pkg::DSQ_WR_GAP;
                            field_cnt <= 16'(dsq_pkg::GAP_LEN);
                        end else begin
                            write_gate <= 1'b0;
                            state <= dsq_pkg::DSQ_DONE;
                        end
                    end else if (byte_tick) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_WR_GAP: begin
                    if (byte_tick && last_field) begin
                        write_gate <= 1'b0;
                        state <= dsq_pkg::DSQ_DONE;
                    end else if (byte_tick) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_RD_AM: begin
                    if (header_post_done) begin
                        read_gate <= 1'b1;
                        crc_on <= ctrl[dsq_pkg::CTRL_ENCAP];
                    end
                    if (read_gate && rd_byte_valid) begin
                        if (rd_byte == amark) begin
                            state <= dsq_pkg::DSQ_RD_SYNC;
                        end else begin
                            state <= dsq_pkg::DSQ_IDLE;
                            read_gate <= 1'b0;
                            ev_set[dsq_pkg::ST_ABORT] <= 1'b1;
                        end
                    end
                end
                dsq_pkg::DSQ_RD_SYNC: begin
                    if (rd_byte_valid) begin
                        if (rd_byte == sync_pat) begin
                            crc_on <= 1'b1;
                            state <= dsq_pkg::DSQ_RD_DATA;
                            field_cnt <= dsq_pkg::DATA_LEN_RESET;
                        end else begin
                            state <= dsq_pkg::DSQ_IDLE;
                            read_gate <= 1'b0;
                            ev_set[dsq_pkg::ST_ABORT] <= 1'b1;
                        end
                    end
                end
                dsq_pkg::DSQ_RD_DATA: begin
                    // Count-only for check; FIFO overflow is not guarded
                    if (rd_byte_valid && last_field) begin
                        state <= dsq_pkg::DSQ_RD_CRC;
                        field_cnt <= 16'(dsq_pkg::CRC_LEN);
                    end else if (rd_byte_valid) begin
                        field_cnt <= field_cnt - 16'h0001;
                    end
                end
                dsq_pkg::DSQ_RD_CRC: begin
                    if (rd_byte_valid) begin
                        if (rd_byte != (last_field ? crc[7:0]
                                                   : crc[15:8])) begin
                            crc_bad <= 1'b1;
                        end
                        if (last_field) begin
                            read_gate <= 1'b0;
                            state <= dsq_pkg::DSQ_DONE;
                            ev_set[dsq_pkg::ST_CRC_ERR] <= crc_bad
                                || rd_byte != crc[7:0];
                        end else begin
                            field_cnt <= field_cnt - 16'h0001;
                        end
                    end
                end
                dsq_pkg::DSQ_DONE: begin
                    ev_set[dsq_pkg::ST_DONE] <=
                        ctrl[dsq_pkg::CTRL_IRQ_EN];
                    start_sector <= start_sector + 8'h01;
                    if (sect_count != 8'h00) begin
                        sect_count <= sect_count - 8'h01;
                    end
                    if ((cmd[dsq_pkg::CMD_MULTI] && sect_count > 8'h01)
                        || cmd_pending) begin
                        cmd_pending <= 1'b0;
                        state <= dsq_pkg::DSQ_WAIT_HDR;
                    end else begin
                        state <= dsq_pkg::DSQ_IDLE;
                    end
                end
                default: state <= dsq_pkg::DSQ_IDLE;
            endcase
        end
    end
endmodule : dsq_sequencer

// ---- inc/dsq_pkg.sv ----
// Constants, register map and state type of the data phase sequencer
package dsq_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_PATTERN = 8'h14;
    localparam logic [7:0] ADDR_AMARK = 8'h18;
    localparam logic [7:0] ADDR_SYNC = 8'h1c;
    localparam logic [7:0] ADDR_SECTOR = 8'h20;
    localparam logic [7:0] ADDR_STATE = 8'h24;
    // Control register fields
    localparam int CTRL_MFM = 0;
    localparam int CTRL_START_AM = 1;
    localparam int CTRL_ENCAP = 2;
    localparam int CTRL_IRQ_EN = 3;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    // Command register fields
    localparam int CMD_OP_LO = 0;
    localparam int CMD_MULTI = 2;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_FORMAT = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_CHECK = 2'h3;
    // Status / mask bits
    localparam int ST_DONE = 0;
    localparam int ST_ABORT = 1;
    localparam int ST_CRC_ERR = 2;
    localparam int ST_NUM = 3;
    // Field lengths in bytes, fill bytes, mark and sync reset values, CRC seed and polynomial
    localparam logic [7:0] AM_LEN = 8'h01;
    localparam logic [7:0] PRE_LEN = 8'h0b;
    localparam logic [7:0] SYNC_LEN = 8'h01;
    localparam logic [7:0] CRC_LEN = 8'h02;
    localparam logic [7:0] POST_LEN = 8'h02;
    localparam logic [7:0] GAP_LEN = 8'h10;
    localparam logic [15:0] DATA_LEN_RESET = 16'h0200;
    localparam logic [7:0] PRE_BYTE = 8'h00;
    localparam logic [7:0] POST_BYTE = 8'h00;
    localparam logic [7:0] GAP_BYTE = 8'h4e;
    localparam logic [7:0] AMARK_RESET = 8'ha1;
    localparam logic [7:0] SYNC_RESET = 8'hfe;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    typedef enum logic [3:0] {
        DSQ_IDLE, DSQ_WAIT_HDR, DSQ_WR_AM, DSQ_WR_PRE, DSQ_WR_SYNC,
        DSQ_WR_DATA, DSQ_WR_CRC, DSQ_WR_POST, DSQ_WR_GAP, DSQ_RD_AM,
        DSQ_RD_SYNC, DSQ_RD_DATA, DSQ_RD_CRC, DSQ_DONE
    } dsq_state_type;
endpackage : dsq_pkg

// ---- dv/dsq_sequencer_props.sv ----
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module dsq_sequencer_props (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic header_match,
    input wire logic header_post_done,
    input wire logic write_gate,
    input wire logic read_gate,
    input wire logic wr_byte_valid,
    input wire logic byte_tick,
    input wire logic fifo_rd_ready,
    input wire logic fifo_wr_valid,
    input wire logic rd_byte_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_tick;
        write_gate && byte_tick;
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("bus request not acknowledged");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_gate_excl: assert property (!(write_gate && read_gate))
        else $error("both gates high");
    a_wgate_cause: assert property (
        $rose(write_gate) |-> $past(header_match))
        else $error("write gate rose without header match");
    a_rgate_cause: assert property (
        $rose(read_gate) |-> $past(header_post_done))
        else $error("read gate rose before postamble");
    a_byte_paced: assert property (
        wr_byte_valid |-> $past(byte_tick) && $past(write_gate))
        else $error("byte written without gate and tick");
    a_pop_paced: assert property (fifo_rd_ready |-> s_tick)
        else $error("fifo popped off a gated tick");
    a_push_read: assert property (
        fifo_wr_valid |-> $past(rd_byte_valid) && $past(read_gate))
        else $error("fifo push without received byte");
endmodule : dsq_sequencer_props

bind dsq_sequencer dsq_sequencer_props dsq_sequencer_props_inst (.*);

// ---- dv/dsq_channel_model.sv ----
// Drive channel model: write pacing and received sector stream
`timescale 1ns/1ps
module dsq_channel_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic write_gate,
    input wire logic read_gate,
    input wire logic bad_mark,
    input wire logic [7:0] seed,
    input wire logic [15:0] crc_in,
    output logic byte_tick,
    output logic [7:0] rd_byte,
    output logic rd_byte_valid
);
    logic [9:0] cnt;
    logic ph;
    logic go;
    assign go = read_gate && ph && cnt < 10'd516;
    always_ff @(posedge sys_clk) begin
        ph <= !ph && resetn;
        // Ticks stand still outside the write gate
        byte_tick <= write_gate && ph;
        rd_byte_valid <= go;
        cnt <= !read_gate ? 10'd0 : cnt + {9'd0, go};
        if (!resetn)
            rd_byte <= 8'h5a;
        else if (!go)
            rd_byte <= ~rd_byte;
        else if (cnt == 10'd0)
            rd_byte <= dsq_pkg::AMARK_RESET ^ {8{bad_mark}};
        else if (cnt == 10'd1)
            rd_byte <= dsq_pkg::SYNC_RESET;
        else if (cnt >= 10'd514)
            rd_byte <= cnt[0] ? crc_in[7:0] : crc_in[15:8];
        else
            rd_byte <= (cnt[7:0] - 8'h02) ^ seed;
    end
endmodule : dsq_channel_model

// ---- dv/dsq_sequencer_tb.sv ----
// Self-checking bench of the data phase sequencer
`timescale 1ns/1ps
module dsq_sequencer_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic req = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic header_match = 1'b0;
    logic header_post_done = 1'b0;
    logic bad_mark = 1'b0;
    logic [7:0] seed = 8'h00;
    logic [15:0] crc_in = 16'h0;
    logic [31:0] wb_dat_o, rng = 32'he7c3;
    logic wb_ack_o, irq, write_gate, read_gate, wr_byte_valid, byte_tick;
    logic rd_byte_valid, fifo_rd_ready, fifo_wr_valid, mfm_select;
    logic address_mark_enable_output;
    logic [7:0] wr_byte, rd_byte, fifo_wr_data;
    logic [7:0] d [513];
    logic [7:0] q [$];
    int idx = 0;
    int am_hits = 0;
    int err_count = 0;
    int comparisons = 0;
    dsq_sequencer dsq_sequencer_inst (.sys_clk, .resetn, .wb_adr_i, .wb_dat_i,
        .wb_dat_o, .wb_we_i, .wb_sel_i(4'hf), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_ack_o, .irq, .header_match, .header_post_done, .write_gate,
        .read_gate, .mfm_select, .address_mark_enable_output, .wr_byte,
        .wr_byte_valid, .byte_tick, .rd_byte, .rd_byte_valid,
        .fifo_rd_data(d[idx]), .fifo_rd_valid(1'b1), .fifo_rd_ready,
        .fifo_wr_data, .fifo_wr_valid, .fifo_wr_ready(1'b1));
    dsq_channel_model dsq_channel_model_inst (.sys_clk, .resetn, .write_gate,
        .read_gate, .bad_mark, .seed, .crc_in, .byte_tick, .rd_byte,
        .rd_byte_valid);
    initial forever #25 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    function automatic logic [15:0] crc(input logic [15:0] c,
                                        input logic [7:0] b);
        c = c ^ {b, 8'h00};
        repeat (8) c = c[15] ? (c << 1) ^ dsq_pkg::CRC_POLY : c << 1;
        return c;
    endfunction : crc
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] v,
                      output logic [31:0] r);
        int n;
        @(posedge sys_clk);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= v;
        req <= 1'b1;
        for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge sys_clk);
        r = wb_dat_o;
        req <= 1'b0;
        if (n == 20) begin
            err_count++;
            report_and_stop();
        end
    endtask : wb
    function automatic logic [31:0] nxt();
        if (q.size() == 0) return 32'h100;
        return {24'h0, q.pop_front()};
    endfunction : nxt
    // Written and FIFO-pushed bytes are matched in arrival order against the driver's notes
    always @(posedge sys_clk) begin
        if (header_match) idx <= 0;
        else if (fifo_rd_ready === 1'b1) idx <= idx + 1;
        if (header_match) am_hits <= 0;
        else if (address_mark_enable_output === 1'b1) am_hits <= am_hits + 1;
        if (resetn && wr_byte_valid)
            chk("wr_byte", nxt(), wr_byte);
        if (resetn && fifo_wr_valid)
            chk("fifo_wr_data", nxt(), fifo_wr_data);
    end
    // Cases: 0 write, 1 NRZ format with leading mark inside the CRC,
    // 2 read, 3 check, 4 bad mark
    task automatic run(input int k);
        logic [31:0] r;
        logic [15:0] c;
        logic [7:0] s;
        int i;
        r = xs();
        s = r[7:0];
        c = dsq_pkg::CRC_SEED;
        if (k == 1) q.push_back(dsq_pkg::AMARK_RESET);
        if (k < 2) repeat (dsq_pkg::PRE_LEN) q.push_back(dsq_pkg::PRE_BYTE);
        if (k == 0) q.push_back(dsq_pkg::AMARK_RESET);
        if (k < 2) q.push_back(dsq_pkg::SYNC_RESET);
        if (k == 1) begin
            c = crc(c, dsq_pkg::AMARK_RESET);
            repeat (dsq_pkg::PRE_LEN) c = crc(c, dsq_pkg::PRE_BYTE);
            c = crc(c, dsq_pkg::SYNC_RESET);
        end
        for (i = 0; i < 512; i++) begin
            r = xs();
            d[i] = k == 1 ? s : k > 1 ? i[7:0] ^ s : r[7:0];
            c = crc(c, d[i]);
            if (k < 3) q.push_back(d[i]);
        end
        if (k < 2) q.push_back(c[15:8]);
        if (k < 2) q.push_back(c[7:0]);
        if (k < 2) repeat (dsq_pkg::POST_LEN) q.push_back(dsq_pkg::POST_BYTE);
        if (k == 1) repeat (dsq_pkg::GAP_LEN) q.push_back(dsq_pkg::GAP_BYTE);
        seed <= s;
        crc_in <= c;
        bad_mark <= k == 4;
        wb(dsq_pkg::ADDR_PATTERN, 1'b1, {24'h0, s}, r);
        wb(dsq_pkg::ADDR_MASK, 1'b1, k == 3 ? 32'h0 : 32'h3, r);
        wb(dsq_pkg::ADDR_CTRL, 1'b1, k == 1 ? 32'he : 32'h9, r);
        wb(dsq_pkg::ADDR_CMD, 1'b1, k == 4 ? 32'h2 : k, r);
        @(posedge sys_clk);
        header_match <= 1'b1;
        @(posedge sys_clk);
        header_match <= 1'b0;
        header_post_done <= k > 1;
        for (i = 0; i < 1000; i++) begin
            wb(dsq_pkg::ADDR_STATE, 1'b0, 32'h0, r);
            if (r[3:0] === dsq_pkg::DSQ_IDLE) break;
        end
        if (i == 1000) begin
            err_count++;
            report_and_stop();
        end
        chk("irq", k != 3, irq);
        wb(dsq_pkg::ADDR_STATUS, 1'b0, 32'h0, r);
        chk("status", k == 4 ? 32'h2 : 32'h1, r);
        @(posedge sys_clk);
        chk("irq", 0, irq);
        chk("gates", 0, {write_gate, read_gate});
        chk("mfm", k != 1, mfm_select);
        chk("am_enable", k < 2, am_hits != 0);
        chk("queue", 0, q.size());
        header_post_done <= 1'b0;
    endtask : run
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        wb(dsq_pkg::ADDR_CTRL, 1'b0, 32'h0, r);
        chk("ctrl", {24'h0, dsq_pkg::CTRL_RESET}, r);
        wb(8'h3c, 1'b0, 32'h0, r);
        chk("unmapped", 0, r);
        for (int k = 0; k < 5; k++) run(k);
        report_and_stop();
    end
endmodule : dsq_sequencer_tb
